/* pcw_consts.svh */
// Constants for the dual PLL counter control word block.
// Assumes a 10 MHz ref_clk_in and a 32-bit classic Wishbone slave port.
`ifndef PCW_CONSTS_SVH
`define PCW_CONSTS_SVH

// ==========================================================================
// Register byte addresses
`define PCW_ADDR_CTRL 4'h0
`define PCW_ADDR_SLIP 4'h4
`define PCW_ADDR_PWR 4'h8
`define PCW_ADDR_STAT 4'hc

// ==========================================================================
// Control word layout
`define PCW_CTRL_W 24
`define PCW_BIT_QUARTER 13
`define PCW_BIT_AUX_RST 7
`define PCW_BIT_MAIN_RST 6
`define PCW_BIT_AUX_HIZ 5
`define PCW_BIT_MAIN_HIZ 4
`define PCW_CTRL_FIELD_MASK 24'h0020f0
`define PCW_CTRL_FIXED 24'h00090f
`define PCW_CTRL_RESET 24'h00090f

// ==========================================================================
// Cycle slip word layout and decode
`define PCW_SLIP_HI 23
`define PCW_SLIP_LO 22
`define PCW_SLIP_RESET 2'h0
`define PCW_SLIP_OFF 2'h0
`define PCW_SLIP_HALF 2'h1
`define PCW_SLIP_QUARTER 2'h2
`define PCW_SLIP_SIXTEENTH 2'h3
`define PCW_SHIFT_ONE 3'h0
`define PCW_SHIFT_HALF 3'h1
`define PCW_SHIFT_QUARTER 3'h2
`define PCW_SHIFT_SIXTEENTH 3'h4

// ==========================================================================
// Power control and status layout
`define PCW_BIT_SOFT_PD 0
`define PCW_PWR_RESET 1'h0
`define PCW_STAT_ON 0
`define PCW_STAT_AUTO 1
`define PCW_STAT_MAIN_RST 2
`define PCW_STAT_AUX_RST 3
`define PCW_STAT_MAIN_HIZ 4
`define PCW_STAT_AUX_HIZ 5
`define PCW_STAT_SLIP_EN 6
`define PCW_STAT_SHIFT_LO 7

// ==========================================================================
// Timing
`define PCW_CLK_PERIOD_NS 100
`define PCW_PU_RST_TIME_NS 1000
`define PCW_PU_RST_CYCLES ((`PCW_PU_RST_TIME_NS + `PCW_CLK_PERIOD_NS - 1) / `PCW_CLK_PERIOD_NS)
`define PCW_LD_DIV 4

`endif

/* pcw_control_word.sv */
// Counter control word block for a dual PLL synthesizer.
// Assumes a classic Wishbone master, synchronous inputs, one 10 MHz clock.
//
// Function
// RULE1: Slip setting 0 off, else 1/2,1/4,1/16
// RULE2: Slip setting sits in bits 23:22
// RULE3: Fixed bits of control word never change
// RULE4: Quarter-rate bit divides main lock-detect ticks
// RULE5: Auxiliary lock-detect ticks are never divided
// RULE6: Host sets quarter-rate above 20 MHz compare
// RULE7: Aux reset bit holds counters, pump high-Z
// RULE8: Main reset bit holds counters, pump high-Z
// RULE9: Aux high-Z bit floats pump, counters run
// RULE10: Main high-Z bit floats pump, counters run
// RULE11: Every power-up applies a counter reset
// RULE12: Host keeps reset bits zero normally
// RULE13: Host keeps high-Z bits zero normally
// RULE14: Reset release restarts counters, pump resumes
`timescale 1ns/10ps
`default_nettype none
`include "pcw_consts.svh"

module pcw_control_word import pcw_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Power and comparison ticks
  input wire logic chip_enable_in,
  input wire logic main_cmp_tick_in,
  input wire logic aux_cmp_tick_in,
  // PLL controls
  output logic main_counter_reset_out,
  output logic aux_counter_reset_out,
  output logic main_pump_hiz_out,
  output logic aux_pump_hiz_out,
  output logic cycle_slip_rate_cut_en_out,
  output logic [2:0] cycle_slip_rate_cut_shift_out,
  // Lock-detect ticks
  output logic main_ld_tick_out,
  output logic aux_ld_tick_out
);

  // ========================================================================
  // Bus decode
  logic req_w;
  logic wr_w;
  logic rd_w;
  logic [`PCW_CTRL_W-1:0] ctrl_r;
  logic [`PCW_CTRL_W-1:0] ctrl_nxt;
  logic [1:0] slip_r;
  logic pd_r;
  logic [31:0] rdata_nxt;
  logic [31:0] stat_w;

  assign req_w = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_w = req_w && wb_we_in;
  assign rd_w = req_w && !wb_we_in;

  // Single-wait answer; ack drops the cycle after it was given
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= req_w;
    end
  end

  // ========================================================================
  // Control word
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wb_sel_in[0]) begin
      ctrl_nxt[7:0] = wb_dat_in[7:0];
    end
    if (wb_sel_in[1]) begin
      ctrl_nxt[15:8] = wb_dat_in[15:8];
    end
    if (wb_sel_in[2]) begin
      ctrl_nxt[23:16] = wb_dat_in[23:16];
    end
    // Fixed pattern wins over whatever software writes
    ctrl_nxt = (ctrl_nxt & `PCW_CTRL_FIELD_MASK) | `PCW_CTRL_FIXED; // [RULE3]
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl_r <= `PCW_CTRL_RESET;
    end else if (wr_w && wb_adr_in == `PCW_ADDR_CTRL) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Fastlock fields of this word are not kept; only the slip setting
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      slip_r <= `PCW_SLIP_RESET;
    end else if (wr_w && wb_adr_in == `PCW_ADDR_SLIP && wb_sel_in[2]) begin
      slip_r <= wb_dat_in[`PCW_SLIP_HI:`PCW_SLIP_LO]; // [RULE2]
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pd_r <= `PCW_PWR_RESET;
    end else if (wr_w && wb_adr_in == `PCW_ADDR_PWR && wb_sel_in[0]) begin
      pd_r <= wb_dat_in[`PCW_BIT_SOFT_PD];
    end
  end

  // ========================================================================
  // Power-up sequencing
  pcw_pwr_state_t state_r;
  logic [3:0] pu_cnt_r;
  logic on_w;
  logic auto_w;

  assign on_w = chip_enable_in && !pd_r;
  assign auto_w = (state_r != PCW_RUN);

  // Both pin and software power-up pass through the reset state
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_r <= PCW_PU_RST;
    end else begin
      case (state_r)
        PCW_OFF: begin
          if (on_w) begin
            state_r <= PCW_PU_RST; // [RULE11]
          end
        end
        PCW_PU_RST: begin
          if (!on_w) begin
            state_r <= PCW_OFF;
          end else if (pu_cnt_r == 4'(`PCW_PU_RST_CYCLES - 1)) begin
            state_r <= PCW_RUN;
          end
        end
        PCW_RUN: begin
          if (!on_w) begin
            state_r <= PCW_OFF;
          end
        end
        default: begin
          state_r <= PCW_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || state_r != PCW_PU_RST) begin
      pu_cnt_r <= 4'h0;
    end else begin
      pu_cnt_r <= pu_cnt_r + 4'h1;
    end
  end

  // ========================================================================
  // PLL controls
  logic main_rst_nxt;
  logic aux_rst_nxt;
  logic slip_en_nxt;
  logic [2:0] slip_shift_nxt;

  assign main_rst_nxt = ctrl_r[`PCW_BIT_MAIN_RST] || auto_w; // [RULE8] [RULE11]
  assign aux_rst_nxt = ctrl_r[`PCW_BIT_AUX_RST] || auto_w; // [RULE7] [RULE11]

  // Dropping reset releases counters and pump together
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      main_counter_reset_out <= 1'b1;
      aux_counter_reset_out <= 1'b1;
      main_pump_hiz_out <= 1'b1;
      aux_pump_hiz_out <= 1'b1;
    end else begin
      main_counter_reset_out <= main_rst_nxt; // [RULE14]
      aux_counter_reset_out <= aux_rst_nxt;
      main_pump_hiz_out <= ctrl_r[`PCW_BIT_MAIN_HIZ] || main_rst_nxt; // [RULE10]
      aux_pump_hiz_out <= ctrl_r[`PCW_BIT_AUX_HIZ] || aux_rst_nxt; // [RULE9]
    end
  end

  always_comb begin
    case (slip_r) // [RULE1]
      `PCW_SLIP_OFF: begin
        slip_en_nxt = 1'b0;
        slip_shift_nxt = `PCW_SHIFT_ONE;
      end
      `PCW_SLIP_HALF: begin
        slip_en_nxt = 1'b1;
        slip_shift_nxt = `PCW_SHIFT_HALF;
      end
      `PCW_SLIP_QUARTER: begin
        slip_en_nxt = 1'b1;
        slip_shift_nxt = `PCW_SHIFT_QUARTER;
      end
      default: begin
        slip_en_nxt = 1'b1;
        slip_shift_nxt = `PCW_SHIFT_SIXTEENTH;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cycle_slip_rate_cut_en_out <= 1'b0;
      cycle_slip_rate_cut_shift_out <= `PCW_SHIFT_ONE;
    end else begin
      cycle_slip_rate_cut_en_out <= slip_en_nxt;
      cycle_slip_rate_cut_shift_out <= slip_shift_nxt;
    end
  end

  // ========================================================================
  // Lock-detect ticks
  pcw_tick_div u_main_ld (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clear_in(main_counter_reset_out),
    .quarter_in(ctrl_r[`PCW_BIT_QUARTER]), // [RULE4]
    .tick_in(main_cmp_tick_in),
    .tick_out(main_ld_tick_out)
  );

  // Auxiliary path never sees the quarter-rate bit
  pcw_tick_div u_aux_ld (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clear_in(aux_counter_reset_out),
    .quarter_in(1'b0), // [RULE5]
    .tick_in(aux_cmp_tick_in),
    .tick_out(aux_ld_tick_out)
  );

  // ========================================================================
  // Read path
  always_comb begin
    stat_w = 32'h0;
    stat_w[`PCW_STAT_ON] = on_w;
    stat_w[`PCW_STAT_AUTO] = auto_w;
    stat_w[`PCW_STAT_MAIN_RST] = main_counter_reset_out;
    stat_w[`PCW_STAT_AUX_RST] = aux_counter_reset_out;
    stat_w[`PCW_STAT_MAIN_HIZ] = main_pump_hiz_out;
    stat_w[`PCW_STAT_AUX_HIZ] = aux_pump_hiz_out;
    stat_w[`PCW_STAT_SLIP_EN] = cycle_slip_rate_cut_en_out;
    stat_w[`PCW_STAT_SHIFT_LO +: 3] = cycle_slip_rate_cut_shift_out;
  end

  always_comb begin
    case (wb_adr_in)
      `PCW_ADDR_CTRL: rdata_nxt = {8'h0, ctrl_r};
      `PCW_ADDR_SLIP: rdata_nxt = {8'h0, slip_r, 22'h0};
      `PCW_ADDR_PWR: rdata_nxt = {31'h0, pd_r};
      `PCW_ADDR_STAT: rdata_nxt = stat_w;
      default: rdata_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wb_dat_out <= 32'h0;
    end else if (rd_w) begin
      wb_dat_out <= rdata_nxt;
    end
  end

  // ========================================================================
  // Checks
  logic [2:0] gap_r;
  logic armed_r;

  // Counts main ticks since the last divided tick
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || main_counter_reset_out || main_ld_tick_out) begin
      gap_r <= {2'h0, main_cmp_tick_in && !main_counter_reset_out};
    end else if (main_cmp_tick_in && gap_r != 3'h7) begin
      gap_r <= gap_r + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || main_counter_reset_out || !ctrl_r[`PCW_BIT_QUARTER]) begin
      armed_r <= 1'b0;
    end else if (main_ld_tick_out) begin
      armed_r <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  property p_slip_decode;
    (slip_r == `PCW_SLIP_SIXTEENTH) |=>
      (cycle_slip_rate_cut_en_out && cycle_slip_rate_cut_shift_out == 3'h4);
  endproperty
  a_slip_decode: assert property (p_slip_decode) // [RULE1]
    else $error("Slip setting 3 not decoded to one sixteenth");

  property p_slip_field;
    (wr_w && wb_adr_in == `PCW_ADDR_SLIP && wb_sel_in[2]) |=>
      (slip_r == $past(wb_dat_in[23:22]));
  endproperty
  a_slip_field: assert property (p_slip_field) // [RULE2]
    else $error("Slip setting not taken from bits 23:22");

  property p_fixed_bits;
    (wb_ack_out && !wb_we_in && wb_adr_in == `PCW_ADDR_CTRL) |->
      ((wb_dat_out[23:0] & ~`PCW_CTRL_FIELD_MASK) == `PCW_CTRL_FIXED);
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) // [RULE3]
    else $error("Control word fixed bits read back wrong");

  property p_quarter;
    (main_ld_tick_out && armed_r && ctrl_r[`PCW_BIT_QUARTER]) |->
      (gap_r == 3'h4);
  endproperty
  a_quarter: assert property (p_quarter) // [RULE4]
    else $error("Main lock-detect tick not one in four");

  property p_aux_undivided;
    (aux_cmp_tick_in && !aux_counter_reset_out) ##1 !aux_counter_reset_out
      |-> aux_ld_tick_out;
  endproperty
  a_aux_undivided: assert property (p_aux_undivided) // [RULE5]
    else $error("Auxiliary lock-detect tick lost");

  property p_aux_reset;
    ctrl_r[`PCW_BIT_AUX_RST] |=> (aux_counter_reset_out && aux_pump_hiz_out);
  endproperty
  a_aux_reset: assert property (p_aux_reset) // [RULE7]
    else $error("Aux reset bit did not hold counters and pump");

  property p_main_reset;
    ctrl_r[`PCW_BIT_MAIN_RST] |=> (main_counter_reset_out && main_pump_hiz_out);
  endproperty
  a_main_reset: assert property (p_main_reset) // [RULE8]
    else $error("Main reset bit did not hold counters and pump");

  property p_aux_hiz;
    (ctrl_r[`PCW_BIT_AUX_HIZ] && !ctrl_r[`PCW_BIT_AUX_RST] && !auto_w) |=>
      (aux_pump_hiz_out && !aux_counter_reset_out);
  endproperty
  a_aux_hiz: assert property (p_aux_hiz) // [RULE9]
    else $error("Aux high-Z bit wrong effect");

  property p_main_hiz;
    (ctrl_r[`PCW_BIT_MAIN_HIZ] && !ctrl_r[`PCW_BIT_MAIN_RST] && !auto_w) |=>
      (main_pump_hiz_out && !main_counter_reset_out);
  endproperty
  a_main_hiz: assert property (p_main_hiz) // [RULE10]
    else $error("Main high-Z bit wrong effect");

  property p_power_up;
    (state_r == PCW_OFF && on_w) |=> ##1
      (main_counter_reset_out && aux_counter_reset_out) [*8];
  endproperty
  a_power_up: assert property (p_power_up) // [RULE11]
    else $error("Power-up did not apply counter reset");

  property p_release;
    ($fell(ctrl_r[`PCW_BIT_MAIN_RST]) && !auto_w &&
      !ctrl_r[`PCW_BIT_MAIN_HIZ]) |=>
      (!main_counter_reset_out && !main_pump_hiz_out);
  endproperty
  a_release: assert property (p_release) // [RULE14]
    else $error("Main reset release did not resume pump");

  c_power_up: cover property (state_r == PCW_PU_RST ##1 state_r == PCW_RUN);
  c_quarter: cover property (main_ld_tick_out && armed_r);
  c_slip: cover property (cycle_slip_rate_cut_en_out &&
    cycle_slip_rate_cut_shift_out == 3'h2);

endmodule // pcw_control_word

`default_nettype wire

/* pcw_host_model.sv */
// Host side model: a classic Wishbone master that writes control words.
// Assumes the slave answers with a one-cycle ack; the bench bounds hangs.
`timescale 1ns/10ps
`default_nettype none
module pcw_host_model import pcw_pkg::*; (
  // Clock
  input wire logic ref_clk_in,
  // Wishbone master
  input wire logic ack_in,
  output logic cyc_out,
  output logic stb_out,
  output logic we_out,
  output logic [3:0] adr_out,
  output logic [3:0] sel_out,
  output logic [31:0] dat_out
);
  // ==========================================================
  // Bus cycle
  initial begin
    cyc_out = 1'b0;
    stb_out = 1'b0;
    we_out = 1'b0;
    adr_out = 4'h0;
    sel_out = 4'h0;
    dat_out = 32'h0;
  end

  // Request held until ack is sampled, then one idle cycle
  task automatic access(input logic we, input logic [3:0] adr,
                        input logic [3:0] sel, input logic [31:0] dat);
    @(posedge ref_clk_in);
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out <= we;
    adr_out <= adr;
    sel_out <= sel;
    dat_out <= dat;
    // No local limit: a lost answer is left to the bench watchdog
    do begin
      @(posedge ref_clk_in);
    end while (ack_in !== 1'b1);
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    we_out <= 1'b0;
    dat_out <= ~dat;
    @(posedge ref_clk_in);
  endtask
endmodule // pcw_host_model
`default_nettype wire

/* pcw_pkg.sv */
// Types shared by the counter control word block.
// Assumes pcw_consts.svh holds every number.
package pcw_pkg;

  // ========================================================================
  // Power sequencing
  typedef enum logic [1:0] {
    PCW_OFF,
    PCW_PU_RST,
    PCW_RUN
  } pcw_pwr_state_t;

endpackage

/* pcw_tick_div.sv */
// Lock-detect tick divider for one PLL comparison tick stream.
// Assumes tick_in is a one-cycle pulse synchronous to ref_clk_in.
`timescale 1ns/10ps
`default_nettype none
`include "pcw_consts.svh"

module pcw_tick_div import pcw_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Control
  input wire logic clear_in,
  input wire logic quarter_in,
  // Ticks
  input wire logic tick_in,
  output logic tick_out
);

  logic [1:0] cnt_r;
  logic last_w;

  assign last_w = (cnt_r == 2'(`PCW_LD_DIV - 1));

  // Phase restarts with counter reset so the first tick after is clean
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || clear_in || !quarter_in) begin
      cnt_r <= 2'h0;
    end else if (tick_in) begin
      cnt_r <= cnt_r + 2'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || clear_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && (!quarter_in || last_w);
    end
  end

endmodule // pcw_tick_div

`default_nettype wire

/* testbench.sv */
// Self-checking bench for the counter control word block.
// Assumes the host model drives the bus; reads are checked from a queue.
`timescale 1ns/10ps
`default_nettype none
`include "pcw_consts.svh"
module testbench import pcw_pkg::*;;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic chip_enable_in = 1'b1;
  logic main_cmp_tick_in = 1'b0;
  logic aux_cmp_tick_in = 1'b0;
  logic cyc, stb, we;
  logic [3:0] adr, sel;
  logic [31:0] wdat, wb_dat_out;
  logic wb_ack_out, m_rst, a_rst, m_hiz, a_hiz, slip_en, m_ld, a_ld;
  logic [2:0] slip_shift;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int check_count = 0;
  int main_cnt = 0;
  int aux_cnt = 0;
  int ms, as_;
  logic [31:0] w;

  always #50 ref_clk_in = ~ref_clk_in;

  pcw_host_model u_host (.ref_clk_in(ref_clk_in), .ack_in(wb_ack_out),
    .cyc_out(cyc), .stb_out(stb), .we_out(we), .adr_out(adr),
    .sel_out(sel), .dat_out(wdat));

  pcw_control_word u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .chip_enable_in(chip_enable_in),
    .main_cmp_tick_in(main_cmp_tick_in), .aux_cmp_tick_in(aux_cmp_tick_in),
    .main_counter_reset_out(m_rst), .aux_counter_reset_out(a_rst),
    .main_pump_hiz_out(m_hiz), .aux_pump_hiz_out(a_hiz),
    .cycle_slip_rate_cut_en_out(slip_en),
    .cycle_slip_rate_cut_shift_out(slip_shift),
    .main_ld_tick_out(m_ld), .aux_ld_tick_out(a_ld));

  // ==========================================================
  // Checking
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Read answers taken at the ack edge, oldest note first
  always @(posedge ref_clk_in) begin
    if (wb_ack_out === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      chk(wb_dat_out, exp_q.pop_front());
    end
    if (m_ld === 1'b1) main_cnt++;
    if (a_ld === 1'b1) aux_cnt++;
  end

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_host.access(1'b0, a, 4'hf, 32'h0);
  endtask

  // Order: main rst, aux rst, main hiz, aux hiz
  task automatic outs(input logic [3:0] e);
    chk({28'h0, m_rst, a_rst, m_hiz, a_hiz}, {28'h0, e});
  endtask

  task automatic ticks(input int n);
    main_cnt = 0;
    aux_cnt = 0;
    ms = 0;
    as_ = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk_in);
      main_cmp_tick_in <= 1'($urandom % 2);
      aux_cmp_tick_in <= 1'($urandom % 2);
      #1;
      ms += main_cmp_tick_in;
      as_ += aux_cmp_tick_in;
    end
    @(posedge ref_clk_in);
    main_cmp_tick_in <= 1'b0;
    aux_cmp_tick_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(29610));
    wait_cyc(20);
    rst_in <= 1'b0;
    wait_cyc(3);
    outs(4'hf);
    wait_cyc(15);
    outs(4'h0);
    rd(4'h0, 32'h0000090f);
    for (int i = 0; i < 8; i++) begin
      w = $urandom;
      u_host.access(1'b1, 4'h0, 4'hf, w);
      wait_cyc(1);
      outs({w[6], w[7], w[4] | w[6], w[5] | w[7]});
      rd(4'h0, (w & 32'h0020f0) | 32'h00090f);
    end
    u_host.access(1'b1, 4'h1, 4'hf, 32'h0);
    rd(4'h1, 32'h0);
    rd(4'h0, (w & 32'h0020f0) | 32'h00090f);
    u_host.access(1'b1, 4'h0, 4'hf, 32'h0);
    for (int s = 0; s < 4; s++) begin
      u_host.access(1'b1, 4'h4, 4'hf, ($urandom & 32'h3fffff) | (s << 22));
      wait_cyc(1);
      chk({31'h0, slip_en}, {31'h0, s != 0});
      chk({29'h0, slip_shift}, (s == 3) ? 32'h4 : s);
      rd(4'h4, s << 22);
    end
    u_host.access(1'b1, 4'h4, 4'hb, 32'h0);
    rd(4'h4, 32'h00c00000);
    rd(4'hc, 32'h00000241);
    ticks(40);
    chk(main_cnt, ms);
    chk(aux_cnt, as_);
    u_host.access(1'b1, 4'h0, 4'hf, 32'h2000);
    ticks(60);
    chk(main_cnt, ms / 4);
    chk(aux_cnt, as_);
    u_host.access(1'b1, 4'h0, 4'hf, 32'h0080);
    ticks(30);
    chk(main_cnt, ms);
    chk(aux_cnt, 0);
    u_host.access(1'b1, 4'h0, 4'hf, 32'h0040);
    ticks(30);
    chk(main_cnt, 0);
    chk(aux_cnt, as_);
    u_host.access(1'b1, 4'h0, 4'hf, 32'h0);
    ticks(30);
    chk(main_cnt, ms);
    @(posedge ref_clk_in);
    chip_enable_in <= 1'b0;
    wait_cyc(3);
    outs(4'hf);
    chip_enable_in <= 1'b1;
    wait_cyc(3);
    outs(4'hf);
    wait_cyc(15);
    outs(4'h0);
    u_host.access(1'b1, 4'h8, 4'hf, 32'h1);
    // Power-down reaches the outputs two edges after the ack
    wait_cyc(1);
    outs(4'hf);
    u_host.access(1'b1, 4'h8, 4'hf, 32'h0);
    outs(4'hf);
    wait_cyc(15);
    outs(4'h0);
    // Mid-run reset puts the block back into power-up reset
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    wait_cyc(2);
    rst_in <= 1'b0;
    wait_cyc(2);
    outs(4'hf);
    rd(4'h4, 32'h0);
    rd(4'h0, 32'h0000090f);
    end_sim();
  end

  initial begin
    #(100 * 20000);
    num_errors++;
    end_sim();
  end
endmodule // testbench
`default_nettype wire
